//--- tvg_defines.vh
/*
 vendor gpio/control register bank constants: offsets, field positions,
 reset values, write masks and timing figures.
 assumes it is included by bare name from the register bank file; the pin input path does not include it.
*/
// How it works
// - span bit picks 80 mA or 800 mA as the vconn limit maximum
// - limit equals (step code plus one) eighths of the selected maximum
// - limit is applied only while the vconn switch enable input is high
// - writing one to protocol reset pulses the pd phy and fsm reset
// - writing one to full reset restores every register; zeros do nothing
// - both reset bits clear themselves one cycle after being set
// - pin 1 is released unless enabled, then driven to its value bit
// - input level is sampled only while that pin's input enable is set
// - status bit 1 shows pin 2 level, bit 0 shows pin 1
// - role swap function bit switches pin 2 from generic to swap use
// - pin 2 enabled without swap function drives its value bit
// - sink swap mode: host sets value one, device pulls low on disconnect
// - source swap mode: falling pin 2 edge starts swap signalling on the fourth clock after it, unless the protocol reset bit is set then
// - two-bit code selects source and sink dwell time windows
`ifndef TVG_DEFINES_VH
`define TVG_DEFINES_VH

// register offsets
`define TVG_ADDR_VCONN 8'hA0
`define TVG_ADDR_RESET 8'hA2
`define TVG_ADDR_GPIO1 8'hA4
`define TVG_ADDR_GPIO2 8'hA5
`define TVG_ADDR_STAT 8'hA6
`define TVG_ADDR_TOGGLE 8'hA7

// reset values
`define TVG_VCONN_RST 8'h0F
`define TVG_RESET_RST 8'h00
`define TVG_GPIO1_RST 8'h00
`define TVG_GPIO2_RST 8'h00
`define TVG_TOGGLE_RST 8'h00
`define TVG_ZERO8 8'h00

// writable bits of each register
`define TVG_VCONN_WMASK 8'h0F
`define TVG_RESET_WMASK 8'h03
`define TVG_GPIO1_WMASK 8'h07
`define TVG_GPIO2_WMASK 8'h0F
`define TVG_TOGGLE_WMASK 8'h03

// field positions
`define TVG_SPAN_BIT 3
`define TVG_STEP_MSB 2
`define TVG_PROTO_RST_BIT 1
`define TVG_FULL_RST_BIT 0
`define TVG_OUT_EN_BIT 0
`define TVG_IN_EN_BIT 1
`define TVG_OUT_VAL_BIT 2
`define TVG_SWAP_FN_BIT 3
`define TVG_TOGGLE_MSB 1

// vconn limit figures in mA
`define TVG_SPAN_LOW_STEP_MA 10'h00A
`define TVG_SPAN_HIGH_STEP_MA 10'h064

// dwell windows in ms, codes 00b to 11b
`define TVG_SRC_MIN_0 7'h0F
`define TVG_SRC_MIN_1 7'h14
`define TVG_SRC_MIN_2 7'h19
`define TVG_SRC_MIN_3 7'h1E
`define TVG_SNK_MIN_0 7'h23
`define TVG_SNK_MIN_1 7'h1E
`define TVG_SNK_MIN_2 7'h19
`define TVG_SNK_MIN_3 7'h14

`endif

//--- tvg_gpio_pin.v
/*
 one general-purpose pin input path: two-flop synchroniser, gated level
 and a falling-edge pulse.
 assumes the pin is asynchronous to ref_clk.
*/
`timescale 1ns/100ps
`default_nettype none
module tvg_gpio_pin (
   input wire ref_clk,
   input wire nrst,
   input wire clk_en,
   input wire pin_in,
   input wire in_en,
   output reg level_q,
   output reg fell_q
);
   reg sync1_q;
   reg sync2_q;
   reg prev_q;

   // synchroniser; the first stage feeds only the second
   always @(posedge ref_clk) begin
      if (!nrst) begin
         sync1_q <= 1'b0;
         sync2_q <= 1'b0;
         prev_q <= 1'b0;
      end else if (clk_en) begin
         sync1_q <= pin_in;
         sync2_q <= sync1_q;
         prev_q <= sync2_q;
      end
   end

   // level reads zero while the buffer is off, edge only when enabled
   always @(posedge ref_clk) begin
      if (!nrst) begin
         level_q <= 1'b0;
         fell_q <= 1'b0;
      end else if (clk_en) begin
         level_q <= in_en & sync2_q;
         fell_q <= in_en & prev_q & ~sync2_q;
      end
   end
endmodule
`default_nettype wire

//--- tvg_vendor_regs.v
/*
 vendor control register bank: vconn current limit, self-clearing resets,
 two configurable pins with role swap on pin 2, input status and dual-role
 toggle timing selection.
 assumes the register port is driven by a bus slave on ref_clk, and that
 vconn_switch_enable and vbus_disconnect come from logic on ref_clk.
*/
`timescale 1ns/100ps
`default_nettype none
`include "tvg_defines.vh"
module tvg_vendor_regs (
   input wire ref_clk,
   input wire nrst,
   input wire clk_en,
   input wire [7:0] reg_addr,
   input wire [7:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   output reg [7:0] reg_rdata_q,
   input wire vconn_switch_enable,
   input wire vbus_disconnect,
   input wire gpio1_in,
   output reg gpio1_out_q,
   output reg gpio1_oe_q,
   output reg gpio1_in_buf_en_q,
   input wire gpio2_in,
   output reg gpio2_out_q,
   output reg gpio2_oe_q,
   output reg gpio2_in_buf_en_q,
   output reg [9:0] vconn_limit_ma_q,
   output reg vconn_limit_active_q,
   output reg protocol_reset_q,
   output reg swap_signal_start_q,
   output reg [6:0] source_dwell_min_q,
   output reg [6:0] source_dwell_max_q,
   output reg [6:0] sink_dwell_min_q,
   output reg [6:0] sink_dwell_max_q
);

   // stored registers
   reg [7:0] vconn_current_limit_q;
   reg [7:0] soft_reset_control_q;
   reg [7:0] gpio_one_config_q;
   reg [7:0] gpio_two_config_q;
   reg [7:0] toggle_timing_q;
   reg swap_low_q;

   // next values
   reg [7:0] vconn_current_limit_d;
   reg [7:0] soft_reset_control_d;
   reg [7:0] gpio_one_config_d;
   reg [7:0] gpio_two_config_d;
   reg [7:0] toggle_timing_d;
   reg [7:0] rdata_d;

   // synchronised pin state from the input paths
   wire pin1_input_level;
   wire pin2_input_level;
   wire pin1_fell;
   wire pin2_fell;

   // named fields
   wire vconn_limit_span_select;
   wire [2:0] vconn_limit_step;
   wire protocol_reset;
   wire full_register_reset;
   wire pin1_output_value;
   wire pin1_output_enable;
   wire pin1_input_enable;
   wire pin2_output_value;
   wire pin2_output_enable;
   wire pin2_input_enable;
   wire pin2_role_swap_function;
   wire [1:0] toggle_timing_code;
   wire sink_swap_armed;
   wire source_swap_armed;
   wire [7:0] gpio_input_status;

   // limit in mA for a span and step code
   function [9:0] limit_ma;
      input span;
      input [2:0] step;
      reg [9:0] unit;
      reg [9:0] count;
      begin
         unit = span ? `TVG_SPAN_HIGH_STEP_MA : `TVG_SPAN_LOW_STEP_MA;
         count = {7'h00, step} + 10'h001;
         limit_ma = unit * count;
      end
   endfunction

   // shortest dwell in ms for a code; source or sink table
   function [6:0] dwell_min;
      input sink;
      input [1:0] code;
      begin
         case ({sink, code})
            3'h0: dwell_min = `TVG_SRC_MIN_0;
            3'h1: dwell_min = `TVG_SRC_MIN_1;
            3'h2: dwell_min = `TVG_SRC_MIN_2;
            3'h3: dwell_min = `TVG_SRC_MIN_3;
            3'h4: dwell_min = `TVG_SNK_MIN_0;
            3'h5: dwell_min = `TVG_SNK_MIN_1;
            3'h6: dwell_min = `TVG_SNK_MIN_2;
            3'h7: dwell_min = `TVG_SNK_MIN_3;
            default: dwell_min = `TVG_SRC_MIN_0;
         endcase
      end
   endfunction

   // longest dwell: twice the shortest in every code, kept to 7 bits
   function [6:0] dwell_max;
      input sink;
      input [1:0] code;
      reg [6:0] lo;
      begin
         lo = dwell_min(sink, code);
         dwell_max = {lo[5:0], 1'b0};
      end
   endfunction

   // masked write helper: reserved bits never store
   function [7:0] masked;
      input [7:0] data;
      input [7:0] mask;
      begin
         masked = data & mask;
      end
   endfunction

   // field extraction
   assign vconn_limit_span_select = vconn_current_limit_q[`TVG_SPAN_BIT];
   assign vconn_limit_step = vconn_current_limit_q[`TVG_STEP_MSB:0];
   assign protocol_reset = soft_reset_control_q[`TVG_PROTO_RST_BIT];
   assign full_register_reset = soft_reset_control_q[`TVG_FULL_RST_BIT];
   assign pin1_output_value = gpio_one_config_q[`TVG_OUT_VAL_BIT];
   assign pin1_output_enable = gpio_one_config_q[`TVG_OUT_EN_BIT];
   assign pin1_input_enable = gpio_one_config_q[`TVG_IN_EN_BIT];
   assign pin2_output_value = gpio_two_config_q[`TVG_OUT_VAL_BIT];
   assign pin2_output_enable = gpio_two_config_q[`TVG_OUT_EN_BIT];
   assign pin2_input_enable = gpio_two_config_q[`TVG_IN_EN_BIT];
   assign pin2_role_swap_function = gpio_two_config_q[`TVG_SWAP_FN_BIT];
   assign toggle_timing_code = toggle_timing_q[`TVG_TOGGLE_MSB:0];

   // swap mode qualifiers for pin 2
   assign sink_swap_armed = pin2_role_swap_function & pin2_output_enable
      & pin2_output_value;
   assign source_swap_armed = pin2_role_swap_function & ~pin2_output_enable
      & pin2_input_enable;

   // status image; upper bits reserved
   assign gpio_input_status = {6'h00, pin2_input_level, pin1_input_level};

   // input paths for both pins
   tvg_gpio_pin u_pin1 (
      .ref_clk(ref_clk),
      .nrst(nrst),
      .clk_en(clk_en),
      .pin_in(gpio1_in),
      .in_en(pin1_input_enable),
      .level_q(pin1_input_level),
      .fell_q(pin1_fell)
   );

   tvg_gpio_pin u_pin2 (
      .ref_clk(ref_clk),
      .nrst(nrst),
      .clk_en(clk_en),
      .pin_in(gpio2_in),
      .in_en(pin2_input_enable),
      .level_q(pin2_input_level),
      .fell_q(pin2_fell)
   );

   // next register values: a pending full reset beats any write
   always @* begin
      vconn_current_limit_d = vconn_current_limit_q;
      gpio_one_config_d = gpio_one_config_q;
      gpio_two_config_d = gpio_two_config_q;
      toggle_timing_d = toggle_timing_q;
      soft_reset_control_d = `TVG_ZERO8;
      if (full_register_reset) begin
         vconn_current_limit_d = `TVG_VCONN_RST;
         gpio_one_config_d = `TVG_GPIO1_RST;
         gpio_two_config_d = `TVG_GPIO2_RST;
         toggle_timing_d = `TVG_TOGGLE_RST;
         soft_reset_control_d = `TVG_RESET_RST;
      end else if (reg_wr) begin
         case (reg_addr)
            `TVG_ADDR_VCONN:
               vconn_current_limit_d = masked(reg_wdata, `TVG_VCONN_WMASK);
            `TVG_ADDR_RESET:
               soft_reset_control_d = masked(reg_wdata, `TVG_RESET_WMASK);
            `TVG_ADDR_GPIO1:
               gpio_one_config_d = masked(reg_wdata, `TVG_GPIO1_WMASK);
            `TVG_ADDR_GPIO2:
               gpio_two_config_d = masked(reg_wdata, `TVG_GPIO2_WMASK);
            `TVG_ADDR_TOGGLE:
               toggle_timing_d = masked(reg_wdata, `TVG_TOGGLE_WMASK);
            default: begin
               vconn_current_limit_d = vconn_current_limit_q;
            end
         endcase
      end
   end

   // read mux; unmapped and status-only addresses behave as read-only
   always @* begin
      case (reg_addr)
         `TVG_ADDR_VCONN: rdata_d = vconn_current_limit_q;
         `TVG_ADDR_RESET: rdata_d = soft_reset_control_q;
         `TVG_ADDR_GPIO1: rdata_d = gpio_one_config_q;
         `TVG_ADDR_GPIO2: rdata_d = gpio_two_config_q;
         `TVG_ADDR_STAT: rdata_d = gpio_input_status;
         `TVG_ADDR_TOGGLE: rdata_d = toggle_timing_q;
         default: rdata_d = `TVG_ZERO8;
      endcase
   end

   // register storage
   always @(posedge ref_clk) begin
      if (!nrst) begin
         vconn_current_limit_q <= `TVG_VCONN_RST;
         soft_reset_control_q <= `TVG_RESET_RST;
         gpio_one_config_q <= `TVG_GPIO1_RST;
         gpio_two_config_q <= `TVG_GPIO2_RST;
         toggle_timing_q <= `TVG_TOGGLE_RST;
      end else if (clk_en) begin
         vconn_current_limit_q <= vconn_current_limit_d;
         soft_reset_control_q <= soft_reset_control_d;
         gpio_one_config_q <= gpio_one_config_d;
         gpio_two_config_q <= gpio_two_config_d;
         toggle_timing_q <= toggle_timing_d;
      end
   end

   // read data holds until the next read strobe
   always @(posedge ref_clk) begin
      if (!nrst) begin
         reg_rdata_q <= `TVG_ZERO8;
      end else if (clk_en && reg_rd) begin
         reg_rdata_q <= rdata_d;
      end
   end

   // protocol reset output: one pulse per accepted write of one
   always @(posedge ref_clk) begin
      if (!nrst) begin
         protocol_reset_q <= 1'b0;
      end else if (clk_en) begin
         protocol_reset_q <= protocol_reset;
      end
   end

   // vconn limit; reads zero while the switch is off
   always @(posedge ref_clk) begin
      if (!nrst) begin
         vconn_limit_ma_q <= 10'h000;
         vconn_limit_active_q <= 1'b0;
      end else if (clk_en) begin
         vconn_limit_active_q <= vconn_switch_enable;
         if (vconn_switch_enable) begin
            vconn_limit_ma_q <= limit_ma(vconn_limit_span_select,
               vconn_limit_step);
         end else begin
            vconn_limit_ma_q <= 10'h000;
         end
      end
   end

   // pin 1 drive
   always @(posedge ref_clk) begin
      if (!nrst) begin
         gpio1_out_q <= 1'b0;
         gpio1_oe_q <= 1'b0;
         gpio1_in_buf_en_q <= 1'b0;
      end else if (clk_en) begin
         gpio1_oe_q <= pin1_output_enable;
         gpio1_out_q <= pin1_output_enable & pin1_output_value;
         gpio1_in_buf_en_q <= pin1_input_enable;
      end
   end

   // sticky pull-low once disconnect is seen in sink swap mode;
   // disarming wins over a new disconnect in the same cycle
   always @(posedge ref_clk) begin
      if (!nrst) begin
         swap_low_q <= 1'b0;
      end else if (clk_en) begin
         swap_low_q <= sink_swap_armed & (vbus_disconnect | swap_low_q);
      end
   end

   // pin 2 drive: generic value, or value with swap pull-low
   always @(posedge ref_clk) begin
      if (!nrst) begin
         gpio2_out_q <= 1'b0;
         gpio2_oe_q <= 1'b0;
         gpio2_in_buf_en_q <= 1'b0;
      end else if (clk_en) begin
         gpio2_oe_q <= pin2_output_enable;
         gpio2_in_buf_en_q <= pin2_input_enable;
         if (!pin2_output_enable) begin
            gpio2_out_q <= 1'b0;
         end else if (pin2_role_swap_function) begin
            gpio2_out_q <= pin2_output_value & ~swap_low_q
               & ~(sink_swap_armed & vbus_disconnect);
         end else begin
            gpio2_out_q <= pin2_output_value;
         end
      end
   end

   // source swap: a detected falling edge on pin 2 (pin2_fell) starts signalling next cycle unless protocol_reset is set in that cycle
   always @(posedge ref_clk) begin
      if (!nrst) begin
         swap_signal_start_q <= 1'b0;
      end else if (clk_en) begin
         swap_signal_start_q <= source_swap_armed & pin2_fell
            & ~protocol_reset;
      end
   end

   // dwell windows: the longest time is twice the shortest in every code
   always @(posedge ref_clk) begin
      if (!nrst) begin
         source_dwell_min_q <= `TVG_SRC_MIN_0;
         source_dwell_max_q <= dwell_max(1'b0, 2'h0);
         sink_dwell_min_q <= `TVG_SNK_MIN_0;
         sink_dwell_max_q <= dwell_max(1'b1, 2'h0);
      end else if (clk_en) begin
         source_dwell_min_q <= dwell_min(1'b0, toggle_timing_code);
         source_dwell_max_q <= dwell_max(1'b0, toggle_timing_code);
         sink_dwell_min_q <= dwell_min(1'b1, toggle_timing_code);
         sink_dwell_max_q <= dwell_max(1'b1, toggle_timing_code);
      end
   end

endmodule
`default_nettype wire

//--- tvg_pin_partner.sv
/* pin-side partner: resolves one pin from the block drive, an outside
   driver and the board pull-up.
   assumes oe and out come from the block, the outside drive from the bench. */
`timescale 1ns/100ps
`default_nettype none
module tvg_pin_partner (
   input wire logic oe,
   input wire logic out,
   input wire logic ext_drv,
   input wire logic ext_val,
   output logic pin
);
   // block drive wins, then the outside driver, else the pull-up holds it high
   assign pin = oe ? out : (ext_drv ? ext_val : 1'b1);
endmodule
`default_nettype wire

//--- tvg_vendor_regs_props.sv
/* checker for the vendor register bank outputs.
   assumes clk_en drops only briefly and it is bound to tvg_vendor_regs. */
`timescale 1ns/100ps
`default_nettype none
module tvg_vendor_regs_props (
   input wire logic ref_clk,
   input wire logic nrst,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_rdata_q,
   input wire logic vbus_disconnect,
   input wire logic gpio1_oe_q,
   input wire logic gpio2_out_q,
   input wire logic gpio2_oe_q,
   input wire logic gpio2_in_buf_en_q,
   input wire logic [9:0] vconn_limit_ma_q,
   input wire logic vconn_limit_active_q,
   input wire logic protocol_reset_q,
   input wire logic swap_signal_start_q,
   input wire logic [6:0] source_dwell_min_q,
   input wire logic [6:0] source_dwell_max_q,
   input wire logic [6:0] sink_dwell_min_q,
   input wire logic [6:0] sink_dwell_max_q
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!nrst);
   // limit values and their gating
   property p_limit_off;
      !vconn_limit_active_q |-> vconn_limit_ma_q == 10'h000;
   endproperty
   a_limit_off: assert property (p_limit_off) else $error("limit set while switch off");
   property p_limit_grid;
      vconn_limit_ma_q % 10 == 0 && vconn_limit_ma_q <= 10'h320
         && (vconn_limit_ma_q <= 10'h050 || vconn_limit_ma_q % 100 == 0);
   endproperty
   a_limit_grid: assert property (p_limit_grid) else $error("limit off the step grid");
   // self-clearing protocol reset
   property p_prst_cause;
      $rose(protocol_reset_q) |-> $past(reg_wr, 2) && $past(reg_wdata[1], 2)
         && $past(reg_addr, 2) == 8'hA2 ##1 !protocol_reset_q;
   endproperty
   a_prst_cause: assert property (p_prst_cause) else $error("bad protocol reset pulse");
   // pin drive changes only after a write or a disconnect, read data only after a read or write
   property p_sink_fall;
      $fell(gpio2_out_q) |-> $past(vbus_disconnect) || $past(reg_wr, 2) || $past(reg_wr, 3);
   endproperty
   a_sink_fall: assert property (p_sink_fall) else $error("pin 2 fell without cause");
   property p_gpio1_change;
      $changed(gpio1_oe_q) |-> $past(reg_wr, 2) || $past(reg_wr, 3);
   endproperty
   a_gpio1_change: assert property (p_gpio1_change) else $error("pin 1 enable moved alone");
   property p_rdata_hold;
      !$past(reg_rd) && !$past(reg_rd, 2) && !$past(reg_wr, 2) |-> $stable(reg_rdata_q);
   endproperty
   a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved alone");
   // swap start pulse only in source swap mode
   property p_swap_mode;
      swap_signal_start_q |-> !gpio2_oe_q && gpio2_in_buf_en_q ##1 !swap_signal_start_q;
   endproperty
   a_swap_mode: assert property (p_swap_mode) else $error("swap start out of mode");
   // dwell windows
   property p_dwell_sum;
      source_dwell_min_q + sink_dwell_min_q == 7'h32;
   endproperty
   a_dwell_sum: assert property (p_dwell_sum) else $error("dwell pair mismatch");
   property p_dwell_max;
      source_dwell_max_q == {source_dwell_min_q[5:0], 1'b0}
         && sink_dwell_max_q == {sink_dwell_min_q[5:0], 1'b0};
   endproperty
   a_dwell_max: assert property (p_dwell_max) else $error("dwell max not twice min");
   // main scenarios reached
   c_prst: cover property (protocol_reset_q);
   c_swap: cover property (swap_signal_start_q);
   c_sink: cover property ($fell(gpio2_out_q) && $past(vbus_disconnect));
endmodule
bind tvg_vendor_regs tvg_vendor_regs_props i_tvg_vendor_regs_props (.ref_clk, .nrst,
   .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata_q, .vbus_disconnect, .gpio1_oe_q,
   .gpio2_out_q, .gpio2_oe_q, .gpio2_in_buf_en_q, .vconn_limit_ma_q, .vconn_limit_active_q,
   .protocol_reset_q, .swap_signal_start_q, .source_dwell_min_q, .source_dwell_max_q,
   .sink_dwell_min_q, .sink_dwell_max_q);
`default_nettype wire

//--- tcpc_vendor_gpio_control_test.sv
/* testbench for the vendor register bank: registers, pins, swap modes,
   resets and toggle timing.
   assumes the block, its checker and the pin partner are compiled first. */
`timescale 1ns/100ps
`default_nettype none
module tcpc_vendor_gpio_control_test;
   logic ref_clk = 1'b0, nrst = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, en = 1'b0, disc = 1'b0;
   logic ce = 1'b1;
   logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00;
   logic [1:0] ext_drv = 2'h0, ext_val = 2'h0;
   wire [7:0] rdata;
   wire [9:0] lim;
   wire [6:0] smin, smax, kmin, kmax;
   wire p1, p2, o1, e1, o2, e2, prst, swp, b1, b2, act;
   int error_cnt = 0, comparisons = 0, cyc = 0;
   tvg_vendor_regs i_tvg_vendor_regs (.ref_clk(ref_clk), .nrst(nrst), .clk_en(ce),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata_q(rdata), .vconn_switch_enable(en), .vbus_disconnect(disc),
      .gpio1_in(p1), .gpio1_out_q(o1), .gpio1_oe_q(e1), .gpio1_in_buf_en_q(b1),
      .gpio2_in(p2), .gpio2_out_q(o2), .gpio2_oe_q(e2), .gpio2_in_buf_en_q(b2),
      .vconn_limit_ma_q(lim), .vconn_limit_active_q(act), .protocol_reset_q(prst),
      .swap_signal_start_q(swp), .source_dwell_min_q(smin), .source_dwell_max_q(smax),
      .sink_dwell_min_q(kmin), .sink_dwell_max_q(kmax));
   tvg_pin_partner i_tvg_pin_partner (.oe(e1), .out(o1), .ext_drv(ext_drv[0]),
      .ext_val(ext_val[0]), .pin(p1));
   tvg_pin_partner i_tvg_pin_partner_2 (.oe(e2), .out(o2), .ext_drv(ext_drv[1]),
      .ext_val(ext_val[1]), .pin(p2));
   // clock and hang guard
   always #12.5 ref_clk = ~ref_clk;
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 5000) begin
         error_cnt++;
         tally_and_finish();
      end
   end
   task automatic chk(input string name, input logic [9:0] exp, input logic [9:0] got);
      comparisons++;
      if (got !== exp) begin
         error_cnt++;
         $display("[ERR] %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      @(posedge ref_clk);
      @(negedge ref_clk);
      chk($sformatf("reg %h", a), {2'b00, exp}, {2'b00, rdata});
   endtask
   task automatic settle(input int n);
      repeat (n) @(posedge ref_clk);
      @(negedge ref_clk);
   endtask
   // counts swap start pulses over ten cycles after a falling pin 2
   task automatic fall_count(output int n);
      n = 0;
      @(posedge ref_clk);
      ext_val[1] <= 1'b0;
      repeat (10) begin
         @(posedge ref_clk);
         #1 if (swp === 1'b1) n++;
      end
   endtask
   task automatic t_regs_reset;
      for (int a = 8'hA0; a < 8'hA9; a++) rd(8'(a), (a == 8'hA0) ? 8'h0F : 8'h00);
      $display("reset values done");
   endtask
   task automatic t_vconn;
      wr(8'hA0, 8'hF3);
      rd(8'hA0, 8'h03);
      chk("limit off", 10'h000, lim);
      @(posedge ref_clk);
      en <= 1'b1;
      for (int s = 0; s < 2; s++) for (int c = 0; c < 8; c++) begin
         wr(8'hA0, 8'((s << 3) | c));
         settle(2);
         chk("limit", 10'((c + 1) * (s ? 100 : 10)), lim);
      end
      chk("limit active", 10'h001, {9'h000, act});
      @(posedge ref_clk);
      en <= 1'b0;
      settle(2);
      chk("limit off", 10'h000, lim);
      chk("limit inactive", 10'h000, {9'h000, act});
      $display("vconn done");
   endtask
   task automatic t_gpio;
      wr(8'hA4, 8'h05);
      settle(2);
      chk("pin1 drive", 10'h003, {8'h00, e1, o1});
      wr(8'hA4, 8'hFA);
      rd(8'hA4, 8'h02);
      chk("input buffers", 10'h001, {8'h00, b2, b1});
      @(posedge ref_clk);
      ext_drv <= 2'h3;
      ext_val <= 2'h1;
      settle(4);
      chk("pin1 released", 10'h000, {9'h000, e1});
      rd(8'hA6, 8'h01);
      wr(8'hA5, 8'h02);
      settle(4);
      rd(8'hA6, 8'h01);
      @(posedge ref_clk);
      ext_val <= 2'h3;
      settle(4);
      rd(8'hA6, 8'h03);
      wr(8'hA4, 8'h00);
      settle(4);
      rd(8'hA6, 8'h02);
      @(posedge ref_clk);
      ext_drv <= 2'h0;
      wr(8'hA5, 8'h05);
      settle(2);
      chk("pin2 drive", 10'h003, {8'h00, e2, o2});
      wr(8'hA5, 8'h01);
      settle(2);
      chk("pin2 drive", 10'h002, {8'h00, e2, o2});
      $display("pins done");
   endtask
   task automatic t_swap;
      int n;
      wr(8'hA5, 8'h0D);
      settle(2);
      chk("sink armed", 10'h003, {8'h00, e2, o2});
      @(posedge ref_clk);
      disc <= 1'b1;
      @(posedge ref_clk);
      disc <= 1'b0;
      settle(1);
      chk("sink pull low", 10'h002, {8'h00, e2, o2});
      wr(8'hA5, 8'h0A);
      @(posedge ref_clk);
      ext_drv[1] <= 1'b1;
      ext_val[1] <= 1'b1;
      settle(4);
      fall_count(n);
      chk("swap starts", 10'h001, 10'(n));
      wr(8'hA5, 8'h02);
      @(posedge ref_clk);
      ext_val[1] <= 1'b1;
      settle(4);
      fall_count(n);
      chk("generic starts", 10'h000, 10'(n));
      $display("swap done");
   endtask
   task automatic t_toggle;
      int src;
      for (int c = 0; c < 4; c++) begin
         wr(8'hA7, 8'(c));
         settle(2);
         src = 15 + 5 * c;
         chk("source dwell min", 10'(src), {3'h0, smin});
         chk("source dwell max", 10'(2 * src), {3'h0, smax});
         chk("sink dwell min", 10'(50 - src), {3'h0, kmin});
         chk("sink dwell max", 10'(2 * (50 - src)), {3'h0, kmax});
      end
      $display("toggle done");
   endtask
   task automatic t_resets;
      int n;
      wr(8'hA2, 8'h02);
      n = 0;
      repeat (5) begin
         @(posedge ref_clk);
         #1 if (prst === 1'b1) n++;
      end
      chk("protocol reset pulses", 10'h001, 10'(n));
      rd(8'hA2, 8'h00);
      wr(8'hA4, 8'h05);
      wr(8'hA2, 8'h00);
      rd(8'hA7, 8'h03);
      wr(8'hA2, 8'h01);
      settle(3);
      rd(8'hA7, 8'h00);
      rd(8'hA4, 8'h00);
      rd(8'hA2, 8'h00);
      chk("pin1 after reset", 10'h000, {9'h000, e1});
      $display("resets done");
   endtask
   // a write while the clock enable is low must not land
   task automatic t_freeze;
      @(posedge ref_clk);
      ce <= 1'b0;
      wr(8'hA7, 8'h02);
      @(posedge ref_clk);
      ce <= 1'b1;
      rd(8'hA7, 8'h00);
      wr(8'hA7, 8'h02);
      rd(8'hA7, 8'h02);
      $display("freeze done");
   endtask
   task automatic tally_and_finish;
      $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   // main sequence
   initial begin
      repeat (8) @(posedge ref_clk);
      nrst <= 1'b1;
      t_regs_reset();
      t_vconn();
      t_gpio();
      t_swap();
      t_toggle();
      t_resets();
      t_freeze();
      tally_and_finish();
   end
endmodule
`default_nettype wire
